// ### ebss_mem_model.sv
// External memory partner for the bus strobe select block
`timescale 1ns/1ps
module ebss_mem_model (
	input  wire logic       clock,
	input  wire logic       page,
	input  wire logic       use_rd,
	input  wire logic [3:0] wait_n,
	input  wire logic       addr_latch,
	input  wire logic       program_read_strobe_n,
	input  wire logic       write_strobe_n,
	input  wire logic [7:0] port0_out,
	input  wire logic [7:0] port2_out,
	input  wire logic       p37_out,
	input  wire logic       p37_oe_n,
	output logic      [7:0] port0_in,
	output logic      [7:0] port2_in,
	output logic            wait_in_n
);
	logic [7:0] mem [256];
	logic [7:0] a = 8'h00;
	logic [7:0] last = 8'h00;
	int         cnt = 0;
	logic       rd;
	logic       act;
	initial foreach (mem[i]) mem[i] = 8'(i) ^ 8'h5a;
	assign rd = !program_read_strobe_n || (use_rd && !p37_oe_n && !p37_out);
	assign act = rd || !write_strobe_n;
	// Pull-up holds wait high outside strobes
	assign wait_in_n = !(act && cnt < wait_n);
	// Released port 0 floats, so show the inverse of the last byte
	assign port0_in = rd ? mem[a] : ~last;
	assign port2_in = rd ? mem[a] : 8'hff;
	always @(posedge clock) begin
		if (addr_latch)
			a <= port0_out;
		cnt <= act ? cnt + 1 : 0;
		if (rd)
			last <= mem[a];
		if (!write_strobe_n)
			mem[a] <= page ? port2_out : port0_out;
	end
endmodule

// ### ebss_pkg.sv
// Constants and types for the external bus strobe select block
package ebss_pkg;
	localparam logic [7:0] WAIT_CONTROL_ADDR  = 8'ha7;
	localparam logic [7:0] BUS_STATUS_ADDR    = 8'ha8;
	localparam logic [7:0] WAIT_CONTROL_RESET = 8'h00;
	localparam int         REALTIME_WAIT_BIT  = 0;
	localparam int         WCE_BIT            = 1;
	localparam int         ST_BUSY_BIT        = 0;
	localparam int         ST_WAITING_BIT     = 1;
	localparam int         ST_MSEL_LSB        = 2;
	localparam int         ST_PAGE_BIT        = 4;
	localparam int         MSEL_LSB           = 2;
	localparam int         PAGE_BIT           = 5;
	localparam logic [1:0] MSEL_256K          = 2'h0;
	localparam logic [1:0] MSEL_128K          = 2'h1;
	localparam logic [1:0] MSEL_64K           = 2'h2;
	localparam logic [1:0] MSEL_LEGACY        = 2'h3;
	localparam logic [1:0] MSEL_RESET         = 2'h0;
	localparam logic [23:0] DATA_SPACE_TOP    = 24'h7fffff;
	localparam int         ADDR_BITS          = 24;
	localparam int         DATA_BITS          = 8;
	localparam int         A16_BIT            = 16;
	localparam int         A17_BIT            = 17;

	typedef enum logic [3:0] {
		ST_IDLE   = 4'h1,
		ST_ADDR   = 4'h2,
		ST_STROBE = 4'h4,
		ST_HOLD   = 4'h8
	} ebss_state_t;

	typedef enum logic [1:0] {
		KIND_FETCH = 2'h0,
		KIND_READ  = 2'h1,
		KIND_WRITE = 2'h2
	} ebss_kind_t;
endpackage

// ### ebss_tb_top.sv
// Self-checking bench for the external bus strobe select block
`timescale 1ns/1ps
module ebss_tb_top;
	logic        clock, rst_n, reg_wr, reg_rd, req_valid, req_ready, req_legacy, req_done;
	logic        addr_latch, program_read_strobe_n, write_strobe_n, port0_oe_n, port2_oe_n;
	logic        wait_in_n, p17_gpio_out, p17_gpio_oe_n, p17_out, p17_oe_n, x;
	logic        p37_gpio_out, p37_gpio_oe_n, p37_out, p37_oe_n, page, use_rd, wen, rd_d;
	logic [7:0]  user_config_byte0, reg_addr, reg_wdata, reg_rdata, req_wdata, req_rdata;
	logic [7:0]  port0_out, port0_in, port2_out, port2_in, shadow [256];
	logic [1:0]  req_kind, code;
	logic [23:0] req_addr, a;
	logic [3:0]  wait_n;
	logic [8:0]  bq [$];
	logic [7:0]  rq [$];
	int          miscompares = 0, n_compared = 0, seed;
	bit          hung = 1'b0;
	ebss_top ebss_top_i (
		.clock(clock), .rst_n(rst_n), .user_config_byte0(user_config_byte0),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .req_valid(req_valid), .req_ready(req_ready),
		.req_kind(req_kind), .req_legacy(req_legacy), .req_addr(req_addr),
		.req_wdata(req_wdata), .req_done(req_done), .req_rdata(req_rdata),
		.addr_latch(addr_latch), .program_read_strobe_n(program_read_strobe_n),
		.write_strobe_n(write_strobe_n), .port0_out(port0_out), .port0_oe_n(port0_oe_n),
		.port0_in(port0_in), .port2_out(port2_out), .port2_oe_n(port2_oe_n),
		.port2_in(port2_in), .wait_in_n(wait_in_n), .p17_gpio_out(p17_gpio_out),
		.p17_gpio_oe_n(p17_gpio_oe_n), .p17_out(p17_out), .p17_oe_n(p17_oe_n),
		.p37_gpio_out(p37_gpio_out), .p37_gpio_oe_n(p37_gpio_oe_n), .p37_out(p37_out),
		.p37_oe_n(p37_oe_n)
	);
	ebss_mem_model ebss_mem_model_i (
		.clock(clock), .page(page), .use_rd(use_rd), .wait_n(wait_n),
		.addr_latch(addr_latch), .program_read_strobe_n(program_read_strobe_n),
		.write_strobe_n(write_strobe_n), .port0_out(port0_out), .port2_out(port2_out),
		.p37_out(p37_out), .p37_oe_n(p37_oe_n), .port0_in(port0_in),
		.port2_in(port2_in), .wait_in_n(wait_in_n)
	);
	initial clock = 0;
	always #4 clock = ~clock;
	task automatic chk(input logic c);
		n_compared++;
		if (c !== 1'b1) begin
			miscompares++;
			$display("BAD %0t value differs", $time);
		end
	endtask
	task automatic end_sim;
		$display("compared %0d, miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic wr(input logic [7:0] ad, d);
		@(posedge clock);
		reg_wr <= 1; reg_addr <= ad; reg_wdata <= d;
		@(posedge clock);
		reg_wr <= 0;
	endtask
	task automatic rd(input logic [7:0] ad, e);
		@(posedge clock);
		reg_rd <= 1; reg_addr <= ad; rq.push_back(e);
		@(posedge clock);
		reg_rd <= 0;
	endtask
	always @(posedge clock) rd_d <= reg_rd;
	// Read data stand one cycle only, so look mid-cycle
	always @(negedge clock) begin
		if (rd_d) chk(reg_rdata === rq.pop_front());
		else chk(reg_rdata === 8'h00);
		if (req_done === 1'b1 && bq.size() > 0 && bq[0][8]) chk(req_rdata === bq[0][7:0]);
		if (req_done === 1'b1 && bq.size() > 0) void'(bq.pop_front());
	end
	task automatic bus(input logic [1:0] k, input logic lg, input logic [23:0] ad);
		logic [7:0] d;
		logic ps, ws, rs, eps, ews, ers;
		int n;
		if (hung) return;
		d = 8'($random(seed));
		ps = 1; ws = 1; rs = 1; n = 0;
		eps = k != ebss_pkg::KIND_WRITE && (code != ebss_pkg::MSEL_LEGACY || ad[23]);
		ers = k != ebss_pkg::KIND_WRITE && code == ebss_pkg::MSEL_LEGACY && !ad[23];
		ews = k == ebss_pkg::KIND_WRITE && (code != ebss_pkg::MSEL_LEGACY || lg);
		@(posedge clock);
		req_valid <= 1; req_kind <= k; req_legacy <= lg; req_addr <= ad; req_wdata <= d;
		wait_n <= 4'($random(seed)) & 4'h3;
		bq.push_back({k != ebss_pkg::KIND_WRITE, shadow[ad[7:0]]});
		if (ews) shadow[ad[7:0]] = d;
		@(posedge clock);
		req_valid <= 0;
		while (req_done !== 1'b1 && n < 40) begin
			@(negedge clock);
			n++;
			ps &= program_read_strobe_n;
			ws &= write_strobe_n;
			if (code == ebss_pkg::MSEL_LEGACY) rs &= !(p37_oe_n === 0 && p37_out === 0);
			if (page && !(program_read_strobe_n && write_strobe_n)) chk(port0_out === ad[7:0]);
			if (write_strobe_n === 1'b0)
				chk((page ? port2_out : port0_out) === d && (page ? port2_oe_n : port0_oe_n) === 1'b0);
			if (program_read_strobe_n === 1'b0)
				chk((page ? port2_oe_n : port0_oe_n) === 1'b1);
			if (addr_latch === 1'b1) begin
				chk(port0_out === ad[7:0] && port2_out === ad[15:8]);
				chk(port0_oe_n === 1'b0 && port2_oe_n === 1'b0 && req_ready === 1'b0);
				if (code < 2) chk(p37_out === ad[16] && p37_oe_n === 0);
				if (code == 0) chk(p17_out === ad[17] && p17_oe_n === 0);
				if (code == 2) chk(p37_out === p37_gpio_out && p37_oe_n === p37_gpio_oe_n);
			end
		end
		if (n >= 40) begin
			miscompares++;
			hung = 1'b1;
			$display("BAD %0t bus cycle timed out", $time);
			return;
		end
		chk(n == 3 + ((wen && (eps || ers || ews)) ? wait_n : 0));
		chk(!ps === eps);
		chk(!rs === ers);
		chk(!ws === ews);
	endtask
	initial begin
		seed = 32'hb9a2;
		{rst_n, reg_wr, reg_rd, req_valid, req_legacy, wen} = '0;
		{reg_addr, reg_wdata, req_wdata, req_addr, req_kind, wait_n} = '0;
		{p17_gpio_out, p17_gpio_oe_n, p37_gpio_out, p37_gpio_oe_n} = 4'($random(seed));
		foreach (shadow[i]) shadow[i] = 8'(i) ^ 8'h5a;
		for (int c = 0; c < 4; c++) begin
			@(posedge clock);
			code = 2'(c); page = c[0]; use_rd = c == 3; wen = 0;
			user_config_byte0 <= {2'b0, c[0], 1'b0, 2'(c), 2'b0};
			rst_n <= 0;
			repeat (10) @(posedge clock);
			rst_n <= 1;
			rd(8'ha7, 8'h00);
			rd(8'ha8, {3'b0, c[0], 2'(c), 2'b0});
			rd(8'h3c, 8'h00);
			@(negedge clock);
			if (c != 0) chk(p17_out === p17_gpio_out && p17_oe_n === p17_gpio_oe_n);
			wr(8'ha7, c[1] ? 8'hfe : 8'hff);
			wen = !c[1];
			rd(8'ha7, {6'h0, 1'b1, !c[1]});
			repeat (3) begin
				a = 24'($random(seed));
				bus(ebss_pkg::KIND_WRITE, 1, a & 24'h7fffff);
				bus(ebss_pkg::KIND_READ, 0, a & 24'h7fffff);
				bus(ebss_pkg::KIND_WRITE, 0, a | 24'h800000);
				bus(ebss_pkg::KIND_FETCH, 0, a | 24'h800000);
			end
			if (c != 0) begin
				@(negedge clock);
				x = p17_out;
				@(negedge clock);
				chk(p17_out === !x && p17_oe_n === 1'b0);
			end
		end
		end_sim;
	end
endmodule

// ### ebss_top.sv
// External bus cycle engine with memory select decode and real-time wait
//
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
module ebss_top (
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic [7:0]  user_config_byte0,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [7:0]  reg_rdata,
	input  wire logic        req_valid,
	output logic             req_ready,
	input  wire logic [1:0]  req_kind,
	input  wire logic        req_legacy,
	input  wire logic [23:0] req_addr,
	input  wire logic [7:0]  req_wdata,
	output logic             req_done,
	output logic      [7:0]  req_rdata,
	output logic             addr_latch,
	output logic             program_read_strobe_n,
	output logic             write_strobe_n,
	output logic      [7:0]  port0_out,
	output logic             port0_oe_n,
	input  wire logic [7:0]  port0_in,
	output logic      [7:0]  port2_out,
	output logic             port2_oe_n,
	input  wire logic [7:0]  port2_in,
	input  wire logic        wait_in_n,
	input  wire logic        p17_gpio_out,
	input  wire logic        p17_gpio_oe_n,
	output logic             p17_out,
	output logic             p17_oe_n,
	input  wire logic        p37_gpio_out,
	input  wire logic        p37_gpio_oe_n,
	output logic             p37_out,
	output logic             p37_oe_n
);
	ebss_pkg::ebss_state_t state;
	ebss_pkg::ebss_state_t next_state;
	logic [7:0]  wait_control;
	logic [1:0]  memory_select_bits;
	logic        page_mode;
	logic [23:0] cyc_addr;
	logic [7:0]  cyc_wdata;
	logic [1:0]  cyc_kind;
	logic        cyc_legacy;
	logic        wait_clock;
	logic        realtime_wait_enable;
	logic        wait_clock_enable;
	logic        in_cycle;
	logic        stall;
	logic        is_write;
	logic        is_read;
	logic        low_space;
	logic        use_data_strobe;
	logic        write_in_scope;

	assign realtime_wait_enable = wait_control[ebss_pkg::REALTIME_WAIT_BIT];
	assign wait_clock_enable    = wait_control[ebss_pkg::WCE_BIT];
	assign in_cycle  = (state != ebss_pkg::ST_IDLE);
	assign is_write  = (cyc_kind == ebss_pkg::KIND_WRITE);
	assign is_read   = !is_write;
	assign low_space = (cyc_addr <= ebss_pkg::DATA_SPACE_TOP);
	// Wait pin is ignored unless enabled, so a floating pin cannot hang the bus
	assign stall = realtime_wait_enable && !wait_in_n;
	assign use_data_strobe = (memory_select_bits == ebss_pkg::MSEL_LEGACY) && low_space;
	assign write_in_scope = (memory_select_bits != ebss_pkg::MSEL_LEGACY) || cyc_legacy;

	// Select bits are a strap: caught while reset is held
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			memory_select_bits <= user_config_byte0[ebss_pkg::MSEL_LSB +: 2];
			page_mode          <= user_config_byte0[ebss_pkg::PAGE_BIT];
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			wait_control <= ebss_pkg::WAIT_CONTROL_RESET;
		end else if (reg_wr && reg_addr == ebss_pkg::WAIT_CONTROL_ADDR) begin
			wait_control <= {6'h00, reg_wdata[1:0]};
		end
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd && reg_addr == ebss_pkg::WAIT_CONTROL_ADDR) begin
			reg_rdata <= wait_control;
		end else if (reg_rd && reg_addr == ebss_pkg::BUS_STATUS_ADDR) begin
			reg_rdata <= {3'h0, page_mode, memory_select_bits,
				(state == ebss_pkg::ST_STROBE) && stall, in_cycle};
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	// Free-running divider; toggles every rising oscillator edge
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			wait_clock <= 1'b0;
		end else begin
			wait_clock <= !wait_clock;
		end
	end

	always_comb begin
		next_state = state;
		unique case (state)
			ebss_pkg::ST_IDLE: begin
				if (req_valid) begin
					next_state = ebss_pkg::ST_ADDR;
				end
			end
			ebss_pkg::ST_ADDR: begin
				next_state = ebss_pkg::ST_STROBE;
			end
			ebss_pkg::ST_STROBE: begin
				if (!stall) begin
					next_state = ebss_pkg::ST_HOLD;
				end
			end
			ebss_pkg::ST_HOLD: begin
				next_state = ebss_pkg::ST_IDLE;
			end
			default: begin
				next_state = ebss_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			state <= ebss_pkg::ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			cyc_addr   <= 24'h000000;
			cyc_wdata  <= 8'h00;
			cyc_kind   <= ebss_pkg::KIND_FETCH;
			cyc_legacy <= 1'b0;
		end else if (req_valid && req_ready) begin
			cyc_addr   <= req_addr;
			cyc_wdata  <= req_wdata;
			cyc_kind   <= req_kind;
			cyc_legacy <= req_legacy;
		end
	end

	// Read data is captured at the strobe's closing edge
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			req_rdata <= 8'h00;
		end else if (state == ebss_pkg::ST_STROBE && !stall && is_read) begin
			req_rdata <= page_mode ? port2_in : port0_in;
		end
	end

	assign req_ready  = (state == ebss_pkg::ST_IDLE);
	assign req_done   = (state == ebss_pkg::ST_HOLD);
	assign addr_latch = (state == ebss_pkg::ST_ADDR);

	always_comb begin
		program_read_strobe_n = 1'b1;
		write_strobe_n        = 1'b1;
		if (state == ebss_pkg::ST_STROBE) begin
			if (is_read && !use_data_strobe) begin
				program_read_strobe_n = 1'b0;
			end
			if (is_write && write_in_scope) begin
				write_strobe_n = 1'b0;
			end
		end
	end

	// Port 0 and port 2: multiplexed or page-mode layout
	always_comb begin
		port0_out  = cyc_addr[7:0];
		port0_oe_n = 1'b1;
		port2_out  = cyc_addr[15:8];
		port2_oe_n = 1'b1;
		if (in_cycle) begin
			if (page_mode) begin
				port0_oe_n = 1'b0;
				port2_oe_n = 1'b0;
				if (state != ebss_pkg::ST_ADDR) begin
					port2_out  = cyc_wdata;
					port2_oe_n = !is_write;
				end
			end else begin
				port2_oe_n = 1'b0;
				port0_oe_n = 1'b0;
				if (state != ebss_pkg::ST_ADDR) begin
					port0_out  = cyc_wdata;
					port0_oe_n = !is_write;
				end
			end
		end
	end

	// Pin 1.7: A17 outranks the wait clock, which outranks the port latch
	always_comb begin
		p17_out  = p17_gpio_out;
		p17_oe_n = p17_gpio_oe_n;
		if (memory_select_bits == ebss_pkg::MSEL_256K) begin
			p17_out  = cyc_addr[ebss_pkg::A17_BIT];
			p17_oe_n = 1'b0;
		end else if (wait_clock_enable) begin
			p17_out  = wait_clock;
			p17_oe_n = 1'b0;
		end
	end

	// Pin 3.7: A16, data read strobe, or plain port pin
	always_comb begin
		p37_out  = p37_gpio_out;
		p37_oe_n = p37_gpio_oe_n;
		unique case (memory_select_bits)
			ebss_pkg::MSEL_256K, ebss_pkg::MSEL_128K: begin
				p37_out  = cyc_addr[ebss_pkg::A16_BIT];
				p37_oe_n = 1'b0;
			end
			ebss_pkg::MSEL_64K: begin
				p37_out  = p37_gpio_out;
				p37_oe_n = p37_gpio_oe_n;
			end
			ebss_pkg::MSEL_LEGACY: begin
				p37_out  = !(state == ebss_pkg::ST_STROBE && is_read && use_data_strobe);
				p37_oe_n = 1'b0;
			end
		endcase
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	sequence s_take;
		req_valid && req_ready;
	endsequence
	sequence s_addr_then_strobe;
		addr_latch ##1 (state == ebss_pkg::ST_STROBE);
	endsequence

	a_cycle_order: assert property (s_take |=> s_addr_then_strobe)
		else $error("bus cycle did not run address then strobe");
	a_a17_drive: assert property (memory_select_bits == ebss_pkg::MSEL_256K
		|-> !p17_oe_n && p17_out == cyc_addr[17] && !p37_oe_n && p37_out == cyc_addr[16])
		else $error("upper address bits not driven in 256K code");
	a_upper_free: assert property (memory_select_bits == ebss_pkg::MSEL_64K
		|-> p37_out == p37_gpio_out && p37_oe_n == p37_gpio_oe_n)
		else $error("port 3.7 not left to the port latch in 64K code");
	a_data_strobe: assert property ((state == ebss_pkg::ST_STROBE) && is_read
		&& memory_select_bits == ebss_pkg::MSEL_LEGACY
		|-> (p37_out == !low_space) && (program_read_strobe_n == !(!low_space)))
		else $error("read strobe split wrong in legacy code");
	a_wait_ignored: assert property ((state == ebss_pkg::ST_STROBE) && !realtime_wait_enable
		|=> state == ebss_pkg::ST_HOLD)
		else $error("wait input honoured while disabled");
	a_wait_extend: assert property ((state == ebss_pkg::ST_STROBE) && realtime_wait_enable
		&& !wait_in_n |=> state == ebss_pkg::ST_STROBE)
		else $error("cycle not extended by low wait input");
	a_wclk_off: assert property (!wait_clock_enable
		&& memory_select_bits != ebss_pkg::MSEL_256K
		|-> p17_out == p17_gpio_out && p17_oe_n == p17_gpio_oe_n)
		else $error("wait clock driven while disabled");
	a_wclk_toggle: assert property (wait_clock_enable
		&& memory_select_bits != ebss_pkg::MSEL_256K
		&& $stable(wait_control) ##1 wait_clock_enable |-> p17_out != $past(p17_out))
		else $error("wait clock not at half oscillator rate");
	a_write_scope: assert property ((state == ebss_pkg::ST_STROBE) && is_write
		|-> write_strobe_n == !write_in_scope)
		else $error("write strobe scope wrong");
	a_page_addr: assert property (page_mode && in_cycle
		|-> !port0_oe_n && port0_out == cyc_addr[7:0])
		else $error("page mode low address missing on port 0");
	a_program_read_strobe_n_all: assert property ((state == ebss_pkg::ST_STROBE) && is_read
		&& memory_select_bits != ebss_pkg::MSEL_LEGACY |-> !program_read_strobe_n)
		else $error("program read strobe missing");
	a_a16_drive: assert property (memory_select_bits == ebss_pkg::MSEL_128K
		|-> !p37_oe_n && p37_out == cyc_addr[ebss_pkg::A16_BIT])
		else $error("address bit 16 not driven in 128K code");
	a_page_data: assert property (page_mode && in_cycle && is_write
		&& state != ebss_pkg::ST_ADDR |-> !port2_oe_n && port2_out == cyc_wdata)
		else $error("page mode write data missing on port 2");
	a_wclk_on: assert property (wait_clock_enable
		&& memory_select_bits != ebss_pkg::MSEL_256K |-> !p17_oe_n && p17_out == wait_clock)
		else $error("wait clock not driven while enabled");
	a_legacy_write: assert property ((state == ebss_pkg::ST_STROBE) && is_write
		&& memory_select_bits == ebss_pkg::MSEL_LEGACY && !cyc_legacy |-> write_strobe_n)
		else $error("write strobe outside legacy data space");
endmodule
